//--- hdl/tscc_pkg.sv
// constants and carrier types for the timer channel status and control block
// assumes an 8-bit register port and a 10 MHz system clock
//
// Behaviour
// - capture mode: flag set when the selected edge appears on the channel pin
// - compare mode: flag set when the timer count equals the channel value
// - flag cleared only by reading it set, then writing zero to it; here a disabled odd channel also has its flag cleared
// - an event between that read and the zero write keeps the flag set
// - reset clears every flag; writing one to a flag changes nothing
// - even channels: flag, enable, buffered, mode, edge pair, overflow toggle, full duty
// - channel interrupt request is the flag gated by its enable; reset clears enable
// - capture edge field: 01 rising, 10 falling, 11 either edge
// - buffered even channel disables next odd channel, its pin goes to port control
package tscc_pkg;

   // ************************************************************
   // sizes and register map
   // ************************************************************
   localparam int          TSCC_CHANNELS       = 6;
   localparam logic [7:0]  TSCC_CHAN_ADDR [0:5] = '{8'h26, 8'h29, 8'h2C, 8'h2F, 8'h32, 8'h35};
   localparam logic [7:0]  TSCC_IRQ_STAT_ADDR  = 8'h38;
   localparam logic [7:0]  TSCC_IRQ_MASK_ADDR  = 8'h39;
   localparam logic [7:0]  TSCC_CTL_RESET      = 8'h00;
   localparam logic [5:0]  TSCC_IRQ_RESET      = 6'h00;
   localparam logic [7:0]  TSCC_RD_IDLE        = 8'h00;

   // ************************************************************
   // field positions of a channel register
   // ************************************************************
   localparam int TSCC_BIT_FLAG = 7;
   localparam int TSCC_BIT_IE   = 6;
   localparam int TSCC_BIT_BUF  = 5;

   // edge/level field codes
   localparam logic [1:0] TSCC_ELS_OFF  = 2'h0;
   localparam logic [1:0] TSCC_ELS_RISE = 2'h1;
   localparam logic [1:0] TSCC_ELS_FALL = 2'h2;
   localparam logic [1:0] TSCC_ELS_BOTH = 2'h3;

   // ************************************************************
   // carriers
   // ************************************************************
   // bit order matches the register layout, msb first
   typedef struct packed {
      logic       channel_event_flag;
      logic       channel_irq_enable;
      logic       buffered_mode_select;
      logic       unbuffered_mode_select;
      logic [1:0] edge_level_select;
      logic       overflow_toggle;
      logic       full_duty_force;
   } tscc_ctl_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tscc_bus_req_t;

endpackage : tscc_pkg

//--- hdl/tscc_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes the inputs are asynchronous to clk_sys
`timescale 1ns/100ps
module tscc_sync
   import tscc_pkg::*;
#(
   parameter int W = 6
) (
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   input  wire logic [W-1:0] async_in,
   output      logic [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } tscc_sync_state_t;

   tscc_sync_state_t st;
   tscc_sync_state_t next_st;

   // first stage feeds only the second stage
   always_comb begin
      next_st.meta   = async_in;
      next_st.stable = st.meta;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.stable;

endmodule : tscc_sync

//--- hdl/tscc_channel.sv
// one timer channel: status/control register, event detection, pin drive
// assumes a synchronised pin level and a timer count on clk_sys
`timescale 1ns/100ps
module tscc_channel
   import tscc_pkg::*;
#(
   parameter bit HAS_BUFFER = 1'b1
) (
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        pin_level,
   input  wire logic [15:0] timer_count,
   input  wire logic [15:0] chan_value,
   input  wire logic        timer_overflow,
   input  wire logic        disabled,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   input  wire logic [7:0]  wdata,
   output      tscc_ctl_t   ctl,
   output      logic        event_pulse,
   output      logic        pin_out,
   output      logic        pin_oe
);

   typedef struct packed {
      tscc_ctl_t ctl;
      logic      armed;
      logic      pin_prev;
      logic      pin_out;
      logic      pin_oe;
   } tscc_chan_state_t;

   tscc_chan_state_t st;
   tscc_chan_state_t next_st;
   tscc_ctl_t        wctl;
   logic             cfg_capture;
   logic             cfg_compare;
   logic             edge_hit;
   logic             match;

   // ************************************************************
   // event detection
   // ************************************************************
   always_comb begin
      cfg_capture = !st.ctl.buffered_mode_select && !st.ctl.unbuffered_mode_select
                    && (st.ctl.edge_level_select != TSCC_ELS_OFF);
      cfg_compare = (st.ctl.buffered_mode_select || st.ctl.unbuffered_mode_select)
                    && (st.ctl.edge_level_select != TSCC_ELS_OFF);
      edge_hit = cfg_capture &&
                 ((st.ctl.edge_level_select[0] && pin_level && !st.pin_prev) ||
                  (st.ctl.edge_level_select[1] && !pin_level && st.pin_prev));
      match       = cfg_compare && (timer_count == chan_value);
      event_pulse = !disabled && (edge_hit || match);
   end

   // ************************************************************
   // register, clearing sequence and pin drive
   // ************************************************************
   always_comb begin
      next_st          = st;
      wctl             = tscc_ctl_t'(wdata);
      next_st.pin_prev = pin_level;
      // writes load all control bits at once; flag only by the armed zero write
      if (wr_stb && !disabled) begin
         next_st.ctl.channel_irq_enable     = wctl.channel_irq_enable;
         next_st.ctl.buffered_mode_select   = HAS_BUFFER & wctl.buffered_mode_select;
         next_st.ctl.unbuffered_mode_select = wctl.unbuffered_mode_select;
         next_st.ctl.edge_level_select      = wctl.edge_level_select;
         next_st.ctl.overflow_toggle        = wctl.overflow_toggle;
         next_st.ctl.full_duty_force        = wctl.full_duty_force;
         if (!wctl.channel_event_flag && st.armed) begin
            next_st.ctl.channel_event_flag = 1'b0;
         end
         next_st.armed = 1'b0;
      end
      // a read that sees the flag set arms the clear
      if (rd_stb && !disabled) begin
         next_st.armed = st.ctl.channel_event_flag;
      end
      // a fresh event wins over the clear and disarms it
      if (event_pulse) begin
         next_st.ctl.channel_event_flag = 1'b1;
         next_st.armed                  = 1'b0;
      end
      // pin action; overflow toggle takes precedence over a compare
      if (st.ctl.edge_level_select == TSCC_ELS_OFF) begin
         next_st.pin_out = !st.ctl.unbuffered_mode_select;
      end else if (cfg_compare) begin
         if (timer_overflow && st.ctl.overflow_toggle) begin
            next_st.pin_out = !st.pin_out;
         end else if (match) begin
            unique case (st.ctl.edge_level_select)
               TSCC_ELS_RISE: next_st.pin_out = !st.pin_out;
               TSCC_ELS_FALL: next_st.pin_out = 1'b0;
               TSCC_ELS_BOTH: next_st.pin_out = 1'b1;
               default:       next_st.pin_out = st.pin_out;
            endcase
         end
         if (st.ctl.overflow_toggle && st.ctl.full_duty_force) begin
            next_st.pin_out = 1'b1;
         end
      end
      next_st.pin_oe = cfg_compare && !disabled;
      // a disabled odd channel sits at its reset value
      if (disabled) begin
         next_st.ctl   = tscc_ctl_t'(TSCC_CTL_RESET);
         next_st.armed = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign ctl     = st.ctl;
   assign pin_out = st.pin_out;
   assign pin_oe  = st.pin_oe;

endmodule : tscc_channel

//--- hdl/tscc_top.sv
// six-channel timer status and control block with register port and interrupt
// assumes timer count, overflow and channel values come from logic on clk_sys
// assumes channel pins are asynchronous and are synchronised here
`timescale 1ns/100ps
module tscc_top
   import tscc_pkg::*;
(
   input  wire logic                       clk_sys,
   input  wire logic                       nrst,
   input  wire tscc_bus_req_t              bus_req,
   output      logic [7:0]                 rd_data,
   input  wire logic [15:0]                timer_count,
   input  wire logic                       timer_overflow,
   input  wire logic [TSCC_CHANNELS-1:0][15:0] chan_value,
   input  wire logic [TSCC_CHANNELS-1:0]   chan_pin_in,
   output      logic [TSCC_CHANNELS-1:0]   chan_pin_out,
   output      logic [TSCC_CHANNELS-1:0]   chan_pin_oe,
   output      logic [TSCC_CHANNELS-1:0]   chan_port_ctl,
   output      logic [TSCC_CHANNELS-1:0]   chan_irq_req,
   output      logic                       irq
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [7:0]               rd_data;
      logic [TSCC_CHANNELS-1:0] irq_status;
      logic [TSCC_CHANNELS-1:0] irq_mask;
      logic                     irq;
      logic [TSCC_CHANNELS-1:0] chan_irq_req;
      logic [TSCC_CHANNELS-1:0] port_ctl;
   } tscc_top_state_t;

   tscc_top_state_t          st;
   tscc_top_state_t          next_st;

   logic [TSCC_CHANNELS-1:0] pin_sync;
   logic [TSCC_CHANNELS-1:0] chan_wr;
   logic [TSCC_CHANNELS-1:0] chan_rd;
   logic [TSCC_CHANNELS-1:0] chan_off;
   logic [TSCC_CHANNELS-1:0] chan_event;
   tscc_ctl_t                chan_ctl [TSCC_CHANNELS];
   logic                     stat_wr;
   logic                     mask_wr;
   logic                     stat_rd;
   logic                     mask_rd;

   // ************************************************************
   // pin synchroniser
   // ************************************************************
   // capture edges are judged only on the second stage
   tscc_sync #(
      .W (TSCC_CHANNELS)
   ) u_pin_sync (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .async_in (chan_pin_in),
      .sync_out (pin_sync)
   );

   // ************************************************************
   // address decode
   // ************************************************************
   // interrupt registers sit just above the channel block
   assign stat_wr = bus_req.wr && (bus_req.addr == TSCC_IRQ_STAT_ADDR);
   assign mask_wr = bus_req.wr && (bus_req.addr == TSCC_IRQ_MASK_ADDR);
   assign stat_rd = bus_req.rd && (bus_req.addr == TSCC_IRQ_STAT_ADDR);
   assign mask_rd = bus_req.rd && (bus_req.addr == TSCC_IRQ_MASK_ADDR);

   // ************************************************************
   // channels
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < TSCC_CHANNELS; gi++) begin : g_chan
         // per-channel strobes
         assign chan_wr[gi] = bus_req.wr && (bus_req.addr == TSCC_CHAN_ADDR[gi]);
         assign chan_rd[gi] = bus_req.rd && (bus_req.addr == TSCC_CHAN_ADDR[gi]);

         // odd channel shut off while its even partner is buffered
         if ((gi % 2) == 1) begin : g_odd
            assign chan_off[gi] = chan_ctl[gi-1].buffered_mode_select;
         end else begin : g_even
            assign chan_off[gi] = 1'b0;
         end

         tscc_channel #(
            .HAS_BUFFER ((gi % 2) == 0)
         ) u_chan (
            .clk_sys        (clk_sys),
            .nrst           (nrst),
            .pin_level      (pin_sync[gi]),
            .timer_count    (timer_count),
            .chan_value     (chan_value[gi]),
            .timer_overflow (timer_overflow),
            .disabled       (chan_off[gi]),
            .wr_stb         (chan_wr[gi]),
            .rd_stb         (chan_rd[gi]),
            .wdata          (bus_req.wdata),
            .ctl            (chan_ctl[gi]),
            .event_pulse    (chan_event[gi]),
            .pin_out        (chan_pin_out[gi]),
            .pin_oe         (chan_pin_oe[gi])
         );
      end
   endgenerate

   // ************************************************************
   // read data, interrupt status and requests
   // ************************************************************
   always_comb begin
      next_st = st;
      // read data stand only in the cycle after the read strobe
      next_st.rd_data = TSCC_RD_IDLE;
      for (int i = 0; i < TSCC_CHANNELS; i++) begin
         if (chan_rd[i] && !chan_off[i]) begin
            next_st.rd_data = chan_ctl[i];
         end
      end
      if (stat_rd) begin
         next_st.rd_data = {2'b00, st.irq_status};
      end
      if (mask_rd) begin
         next_st.rd_data = {2'b00, st.irq_mask};
      end
      // sticky status: write one clears, a same-cycle event wins
      next_st.irq_status = st.irq_status;
      if (stat_wr) begin
         next_st.irq_status = st.irq_status & ~bus_req.wdata[TSCC_CHANNELS-1:0];
      end
      next_st.irq_status = next_st.irq_status | chan_event;
      if (mask_wr) begin
         next_st.irq_mask = bus_req.wdata[TSCC_CHANNELS-1:0];
      end
      next_st.irq = |(next_st.irq_status & next_st.irq_mask);
      // per-channel request follows flag and enable
      for (int i = 0; i < TSCC_CHANNELS; i++) begin
         next_st.chan_irq_req[i] = chan_ctl[i].channel_event_flag
                                   && chan_ctl[i].channel_irq_enable;
         next_st.port_ctl[i]     = chan_off[i]
                                   || (chan_ctl[i].edge_level_select == TSCC_ELS_OFF);
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st              <= '0;
         st.irq_status   <= TSCC_IRQ_RESET;
         st.irq_mask     <= TSCC_IRQ_RESET;
         st.port_ctl     <= '1;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign rd_data       = st.rd_data;
   assign irq           = st.irq;
   assign chan_irq_req  = st.chan_irq_req;
   assign chan_port_ctl = st.port_ctl;

endmodule : tscc_top

//--- dv/tscc_pin_model.sv
// far side of the channel pins: an outside source of pin levels
// assumes the bench sets the levels it wants and the block may drive back
`timescale 1ns/100ps
module tscc_pin_model
   import tscc_pkg::*;
(
   input  wire logic [TSCC_CHANNELS-1:0] src_level,
   input  wire logic [TSCC_CHANNELS-1:0] chan_pin_out,
   input  wire logic [TSCC_CHANNELS-1:0] chan_pin_oe,
   output      logic [TSCC_CHANNELS-1:0] chan_pin_in
);
   // ********
   // wire level
   // ********
   // a driven pin wins, so the source never fights the block's own output
   assign chan_pin_in = (chan_pin_oe & chan_pin_out) | (~chan_pin_oe & src_level);
endmodule : tscc_pin_model

//--- dv/tscc_assertions.sv
// port-level checker for the timer channel block
// assumes one clock, clk_sys, and nrst async active low
`timescale 1ns/100ps
module tscc_checker
   import tscc_pkg::*;
(
   input wire logic                     clk_sys,
   input wire logic                     nrst,
   input wire tscc_bus_req_t            bus_req,
   input wire logic [7:0]               rd_data,
   input wire logic [TSCC_CHANNELS-1:0] chan_pin_oe,
   input wire logic [TSCC_CHANNELS-1:0] chan_port_ctl,
   input wire logic [TSCC_CHANNELS-1:0] chan_irq_req,
   input wire logic                     irq
);
   logic       mapped;
   logic       odd_ch;
   logic [6:0] wr_ctl;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // ********
   // address decode helpers
   // ********
   always_comb begin
      mapped = (bus_req.addr == TSCC_IRQ_STAT_ADDR) || (bus_req.addr == TSCC_IRQ_MASK_ADDR);
      for (int i = 0; i < TSCC_CHANNELS; i++) begin
         if (bus_req.addr == TSCC_CHAN_ADDR[i]) mapped = 1'b1;
      end
   end
   assign odd_ch = (bus_req.addr == TSCC_CHAN_ADDR[1]) || (bus_req.addr == TSCC_CHAN_ADDR[3])
                   || (bus_req.addr == TSCC_CHAN_ADDR[5]);
   assign wr_ctl = bus_req.wdata[6:0];

   // ********
   // properties
   // ********
   rd_idle_a : assert property (!$past(bus_req.rd) |-> rd_data == TSCC_RD_IDLE)
      else $error("read data not idle outside a read");
   unmapped_rd_a : assert property (bus_req.rd && !mapped |=> rd_data == 8'h00)
      else $error("unmapped read returned data");
   odd_rsvd_a : assert property (bus_req.rd && odd_ch |=> !rd_data[5])
      else $error("reserved bit of odd channel read one");
   wr_rd_back_a : assert property (
      bus_req.wr && bus_req.addr == TSCC_CHAN_ADDR[0] ##2 bus_req.rd && bus_req.addr ==
      TSCC_CHAN_ADDR[0] |=> rd_data[6:0] == $past(wr_ctl, 3))
      else $error("control bits not read back as written");
   irq_req_set_a : assert property (
      bus_req.rd && bus_req.addr == TSCC_CHAN_ADDR[0] ##1 rd_data[7:6] == 2'b11
      |-> ##[0:1] chan_irq_req[0])
      else $error("enabled flag gave no channel request");
   irq_req_clr_a : assert property (
      bus_req.rd && bus_req.addr == TSCC_CHAN_ADDR[0] ##1 !rd_data[6]
      |-> ##[0:1] !chan_irq_req[0])
      else $error("channel request without enable");
   port_excl_a : assert property ((chan_pin_oe & chan_port_ctl) == '0)
      else $error("pin driven while under port control");
   buf_disable_a : assert property (
      bus_req.wr && bus_req.addr == TSCC_CHAN_ADDR[0] && bus_req.wdata[5]
      |-> ##[1:3] chan_port_ctl[1] && !chan_pin_oe[1])
      else $error("buffered mode left odd pin with the timer");
   reset_out_a : assert property (
      $rose(nrst) |-> chan_port_ctl == '1 && chan_irq_req == '0 && !irq)
      else $error("outputs not at reset values");

   cover property (bus_req.rd ##1 rd_data[7]);
   cover property ($rose(chan_irq_req[2]));
   cover property ($rose(irq));
endmodule : tscc_checker

bind tscc_top tscc_checker u_chk (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req),
   .rd_data(rd_data), .chan_pin_oe(chan_pin_oe), .chan_port_ctl(chan_port_ctl),
   .chan_irq_req(chan_irq_req), .irq(irq));

//--- dv/tscc_top_tb.sv
// self-checking bench for the timer channel status and control block
// assumes the checker is bound to the top and the pin model feeds the pins
`timescale 1ns/100ps
module tscc_top_tb
   import tscc_pkg::*;
;
   logic                               clk_sys = 1'b0;
   logic                               nrst = 1'b0;
   tscc_bus_req_t                      bus_req = '0;
   logic [7:0]                         rd_data;
   logic [15:0]                        timer_count = 16'h0000;
   logic [TSCC_CHANNELS-1:0][15:0]     chan_value = {TSCC_CHANNELS{16'hFFFF}};
   logic [TSCC_CHANNELS-1:0]           src_level = '0;
   logic [TSCC_CHANNELS-1:0]           chan_pin_in, chan_pin_out, chan_pin_oe;
   logic [TSCC_CHANNELS-1:0]           chan_port_ctl, chan_irq_req;
   logic                               irq;
   int                                 errors = 0;
   int                                 n_compared = 0;

   // ********
   // clock, design and pins
   // ********
   always #50 clk_sys = ~clk_sys;
   tscc_top uut (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .rd_data(rd_data),
      .timer_count(timer_count), .timer_overflow(1'b0), .chan_value(chan_value),
      .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
      .chan_port_ctl(chan_port_ctl), .chan_irq_req(chan_irq_req), .irq(irq));
   tscc_pin_model u_pins (.src_level(src_level), .chan_pin_out(chan_pin_out),
      .chan_pin_oe(chan_pin_oe), .chan_pin_in(chan_pin_in));

   // ********
   // tasks
   // ********
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one-cycle strobes; bus goes idle after each so strobes never merge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus_req <= '0;
   endtask : wr
   task automatic chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus_req <= '0;
      @(negedge clk_sys);
      check($sformatf("reg %h", a), rd_data, exp);
   endtask : chk
   // pin edge, then room for the synchroniser and the flag
   task automatic pin(input int ch, input logic lv);
      @(posedge clk_sys);
      src_level[ch] <= lv;
      repeat (5) @(posedge clk_sys);
   endtask : pin
   task automatic hit();
      @(posedge clk_sys);
      timer_count <= 16'h0010;
      @(posedge clk_sys);
      timer_count <= 16'h0000;
      repeat (2) @(posedge clk_sys);
   endtask : hit
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // ********
   // tests
   // ********
   initial begin
      logic [7:0] cfg;
      logic       ef;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      for (int i = 0; i < 6; i++) chk(TSCC_CHAN_ADDR[i], 8'h00);
      chk(TSCC_IRQ_MASK_ADDR, 8'h00);
      chk(8'h27, 8'h00);
      $display("test reset done");
      // flag writes of one are dropped, odd bit 5 stays zero
      for (int i = 0; i < 6; i++) wr(TSCC_CHAN_ADDR[i], (i % 2) ? 8'hFF : 8'hDF);
      for (int i = 0; i < 6; i++) chk(TSCC_CHAN_ADDR[i], 8'h5F);
      for (int i = 0; i < 6; i++) wr(TSCC_CHAN_ADDR[i], 8'h00);
      $display("test layout done");
      // every capture edge code, with the interrupt path
      wr(TSCC_IRQ_MASK_ADDR, 8'h04);
      for (int c = 1; c < 4; c++) begin
         cfg = {4'h4, c[1:0], 2'b00};
         wr(TSCC_CHAN_ADDR[2], cfg);
         for (int lv = 1; lv >= 0; lv--) begin
            pin(2, lv[0]);
            ef = lv ? c[0] : c[1];
            chk(TSCC_CHAN_ADDR[2], {ef, cfg[6:0]});
            check("irq", {7'h00, irq}, {7'h00, ef});
            check("chan irq", {7'h00, chan_irq_req[2]}, {7'h00, ef});
            wr(TSCC_CHAN_ADDR[2], cfg);
            wr(TSCC_IRQ_STAT_ADDR, 8'h04);
            chk(TSCC_CHAN_ADDR[2], cfg);
         end
      end
      wr(TSCC_IRQ_MASK_ADDR, 8'h00);
      pin(2, 1'b1);
      chk(TSCC_IRQ_STAT_ADDR, 8'h04);
      check("masked irq", {7'h00, irq}, 8'h00);
      $display("test capture done");
      // compare, clear sequence and a lost-clear race
      @(posedge clk_sys);
      chan_value[0] <= 16'h0010;
      // start from a low initial level so the set action shows on the pin
      wr(TSCC_CHAN_ADDR[0], 8'h50);
      wr(TSCC_CHAN_ADDR[0], 8'h5C);
      chk(TSCC_CHAN_ADDR[0], 8'h5C);
      check("pin idle", {6'h00, chan_pin_oe[0], chan_pin_out[0]}, 8'h02);
      hit();
      chk(TSCC_CHAN_ADDR[0], 8'hDC);
      check("pin drive", {6'h00, chan_pin_oe[0], chan_pin_out[0]}, 8'h03);
      hit();
      wr(TSCC_CHAN_ADDR[0], 8'h5C);
      wr(TSCC_CHAN_ADDR[0], 8'h5C);
      chk(TSCC_CHAN_ADDR[0], 8'hDC);
      wr(TSCC_CHAN_ADDR[0], 8'h5C);
      chk(TSCC_CHAN_ADDR[0], 8'h5C);
      $display("test compare done");
      // buffered even channel takes the odd one away
      wr(TSCC_CHAN_ADDR[1], 8'h1C);
      wr(TSCC_CHAN_ADDR[0], 8'h20);
      wr(TSCC_CHAN_ADDR[1], 8'h1C);
      chk(TSCC_CHAN_ADDR[1], 8'h00);
      check("odd pin", {6'h00, chan_port_ctl[1], chan_pin_oe[1]}, 8'h02);
      $display("test buffered done");
      stop_test();
   end

   // watchdog well past the few hundred cycles the tests need
   initial begin
      #2000000;
      errors++;
      stop_test();
   end
endmodule : tscc_top_tb
